// ==== common/bml_pkg.sv ====
package bml_pkg;

  localparam int ADDR_W  = 7;
  localparam int DATA_W  = 8;
  localparam int INSTR_W = 14;

  // operand field positions inside the instruction word
  localparam int DEST_BIT = 7;
  localparam int ADDR_LSB = 0;
  localparam int LIT_LSB  = 0;

  // destination selector values
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // opcode masks and match patterns
  localparam logic [INSTR_W-1:0] BYTE_OP_MASK   = 14'h3f00;
  localparam logic [INSTR_W-1:0] INCREMENT_CODE = 14'h0a00;
  localparam logic [INSTR_W-1:0] OR_ACC_CODE    = 14'h0400;
  localparam logic [INSTR_W-1:0] MOVE_FILE_CODE = 14'h0800;
  localparam logic [INSTR_W-1:0] STORE_MASK     = 14'h3f80;
  localparam logic [INSTR_W-1:0] STORE_CODE     = 14'h0080;
  localparam logic [INSTR_W-1:0] LITERAL_MASK   = 14'h3c00;
  localparam logic [INSTR_W-1:0] LITERAL_CODE   = 14'h3000;
  localparam logic [INSTR_W-1:0] IDLE_MASK      = 14'h3f9f;
  localparam logic [INSTR_W-1:0] IDLE_CODE      = 14'h0000;

  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic              ZERO_RST = 1'b0;
  localparam logic [DATA_W-1:0] ONE      = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;

  typedef logic [INSTR_W-1:0] bml_instr_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_INCREMENT_FILE,
    OP_OR_ACCUMULATOR_FILE,
    OP_MOVE_FILE,
    OP_STORE_ACCUMULATOR,
    OP_LOAD_LITERAL,
    OP_IDLE
  } bml_op_t;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bml_fwr_t;

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic              zero;
    bml_fwr_t          fwr;
    logic              unknown;
  } bml_state_t;

endpackage

// ==== verilog/bml_exec.sv ====
// Function
// - destination bit 0 writes accumulator, 1 writes back to file register
// - seven-bit file address 0..127 and one-bit destination selector accepted
// - increment adds one to file register, routes to destination, updates zero
// - OR accumulator with file register, routes to destination, updates zero
// - move file register to destination and update zero flag
// - store accumulator into file register, flags untouched
// - load eight-bit literal into accumulator, flags untouched
// - literal don't-care bits encoded zero; decoder tolerates them
`timescale 1ns/1ps
`default_nettype none
module bml_exec
  import bml_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                instr_valid,
  input  wire bml_pkg::bml_instr_t instr,
  output logic [bml_pkg::ADDR_W-1:0] file_raddr,
  input  wire logic [bml_pkg::DATA_W-1:0] file_rdata,
  output bml_pkg::bml_fwr_t        file_wr,
  output logic [bml_pkg::DATA_W-1:0] acc,
  output logic                     zero,
  output logic                     unknown_op
);
  import bml_pkg::*;

  bml_state_t        s_q;
  bml_state_t        s_d;
  bml_op_t           op;
  logic              dest;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] lit;
  logic [DATA_W-1:0] fval;
  logic [DATA_W-1:0] res;
  logic              res_valid;

  // decode; literal don't-care bits are masked out, so zeros there are fine
  always_comb
  begin
    dest = instr[DEST_BIT];
    addr = instr[ADDR_LSB +: ADDR_W];
    lit  = instr[LIT_LSB +: DATA_W];
    if (!instr_valid)
      op = OP_NONE;
    else if ((instr & BYTE_OP_MASK) == INCREMENT_CODE)
      op = OP_INCREMENT_FILE;
    else if ((instr & BYTE_OP_MASK) == OR_ACC_CODE)
      op = OP_OR_ACCUMULATOR_FILE;
    else if ((instr & BYTE_OP_MASK) == MOVE_FILE_CODE)
      op = OP_MOVE_FILE;
    else if ((instr & STORE_MASK) == STORE_CODE)
      op = OP_STORE_ACCUMULATOR;
    else if ((instr & LITERAL_MASK) == LITERAL_CODE)
      op = OP_LOAD_LITERAL;
    else if ((instr & IDLE_MASK) == IDLE_CODE)
      op = OP_IDLE;
    else
      op = OP_NONE;
  end

  assign file_raddr = addr;

  // the write lands in the file one cycle late; forward it so a dependent
  // instruction right behind sees the new value instead of a stale read
  always_comb
  begin
    if (s_q.fwr.en && (s_q.fwr.addr == addr))
      fval = s_q.fwr.data;
    else
      fval = file_rdata;
  end

  always_comb
  begin
    s_d            = s_q;
    s_d.fwr.en     = 1'b0;
    s_d.unknown    = 1'b0;
    res            = ZERO_VAL;
    res_valid      = 1'b0;
    case (op)
      OP_INCREMENT_FILE:
      begin
        res       = fval + ONE;
        res_valid = 1'b1;
      end
      OP_OR_ACCUMULATOR_FILE:
      begin
        res       = s_q.acc | fval;
        res_valid = 1'b1;
      end
      OP_MOVE_FILE:
      begin
        res       = fval;
        res_valid = 1'b1;
      end
      OP_STORE_ACCUMULATOR:
      begin
        s_d.fwr.en   = 1'b1;
        s_d.fwr.addr = addr;
        s_d.fwr.data = s_q.acc;
      end
      OP_LOAD_LITERAL:
      begin
        s_d.acc = lit;
      end
      OP_IDLE:
      begin
        s_d.acc = s_q.acc;
      end
      OP_NONE:
      begin
        s_d.unknown = instr_valid;
      end
      default:
      begin
        s_d.unknown = instr_valid;
      end
    endcase
    if (res_valid)
    begin
      s_d.zero = (res == ZERO_VAL);
      if (dest == DEST_ACC)
        s_d.acc = res;
      else
      begin
        s_d.fwr.en   = 1'b1;
        s_d.fwr.addr = addr;
        s_d.fwr.data = res;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q.acc      <= ACC_RST;
      s_q.zero     <= ZERO_RST;
      s_q.fwr.en   <= 1'b0;
      s_q.fwr.addr <= '0;
      s_q.fwr.data <= ZERO_VAL;
      s_q.unknown  <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  assign file_wr    = s_q.fwr;
  assign acc        = s_q.acc;
  assign zero       = s_q.zero;
  assign unknown_op = s_q.unknown;

  // reference file operand (forwarded read value) for checks, independent of the datapath above
  logic [DATA_W-1:0] chk_f;
  assign chk_f = (s_q.fwr.en && s_q.fwr.addr == addr) ? s_q.fwr.data : file_rdata;

  AST_INC_ACC: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_INCREMENT_FILE && !dest) |=> (acc == $past(chk_f) + ONE) && !file_wr.en)
    else $error("increment to accumulator wrong");

  AST_INC_FILE: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_INCREMENT_FILE && dest) |=>
      file_wr.en && file_wr.addr == $past(addr) && file_wr.data == $past(chk_f) + ONE
      && acc == $past(acc))
    else $error("increment to file wrong");

  AST_IOR: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_OR_ACCUMULATOR_FILE && !dest) |=> acc == ($past(acc) | $past(chk_f)))
    else $error("or result wrong");

  AST_MOVE_FILE_OP_Z: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_MOVE_FILE && dest) |=>
      file_wr.data == $past(chk_f) && zero == ($past(chk_f) == ZERO_VAL))
    else $error("move file test wrong");

  AST_STORE: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_STORE_ACCUMULATOR) |=>
      file_wr.en && file_wr.data == $past(acc) && $stable(zero) && $stable(acc))
    else $error("store accumulator wrong");

  AST_LIT: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_LOAD_LITERAL) |=>
      acc == $past(instr[LIT_LSB +: DATA_W]) && $stable(zero) && !file_wr.en)
    else $error("literal load wrong");

  AST_LIT_DC: assert property (@(posedge clk) disable iff (!rst_b)
    (instr_valid && (instr & LITERAL_MASK) == LITERAL_CODE) |-> op == OP_LOAD_LITERAL)
    else $error("literal not decoded");

  AST_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_IDLE) |=> $stable(acc) && $stable(zero) && !file_wr.en && !unknown_op)
    else $error("idle changed state");

  AST_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_OR_ACCUMULATOR_FILE && !dest) |=> zero == (acc == ZERO_VAL))
    else $error("zero flag wrong");

  AST_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_MOVE_FILE) |-> file_raddr == instr[ADDR_LSB +: ADDR_W])
    else $error("file address wrong");

  AST_MOVE_FILE_OP_ACC: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_MOVE_FILE && !dest) |=>
      acc == $past(chk_f) && zero == ($past(chk_f) == ZERO_VAL) && !file_wr.en)
    else $error("move file to accumulator wrong");

  AST_IOR_FILE: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_OR_ACCUMULATOR_FILE && dest) |=>
      file_wr.en && file_wr.data == ($past(acc) | $past(chk_f)) && acc == $past(acc))
    else $error("or to file wrong");

  AST_ZERO_INC: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_INCREMENT_FILE) |=> zero == (($past(chk_f) + ONE) == ZERO_VAL))
    else $error("zero flag after increment wrong");

  AST_STORE_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
    (op == OP_STORE_ACCUMULATOR) |=> file_wr.addr == $past(instr[ADDR_LSB +: ADDR_W]))
    else $error("store address wrong");

  COV_INC_WRAP: cover property (@(posedge clk) disable iff (!rst_b)
    op == OP_INCREMENT_FILE ##1 zero);
  COV_FORWARD: cover property (@(posedge clk) disable iff (!rst_b)
    file_wr.en && op != OP_NONE && file_wr.addr == addr);
  COV_STORE_LIT: cover property (@(posedge clk) disable iff (!rst_b)
    op == OP_LOAD_LITERAL ##1 op == OP_STORE_ACCUMULATOR);
  COV_OR_FILE: cover property (@(posedge clk) disable iff (!rst_b)
    op == OP_OR_ACCUMULATOR_FILE && dest);
endmodule
`default_nettype wire

// ==== sim/bml_regfile_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bml_regfile_model
  import bml_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic [bml_pkg::ADDR_W-1:0] raddr,
  output logic [bml_pkg::DATA_W-1:0]      rdata,
  input  wire bml_pkg::bml_fwr_t          wr
);
  import bml_pkg::*;

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  initial
  begin
    for (int i = 0; i < (1 << ADDR_W); i++)
      mem[i] = 8'h00;
  end

  // commit late on purpose, so a read right after a write sees stale data
  always @(posedge clk)
  begin
    if (wr.en === 1'b1)
      mem[wr.addr] <= wr.data;
  end

  assign rdata = mem[raddr];
endmodule
`default_nettype wire

// ==== sim/test_bml_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_bml_exec;
  import bml_pkg::*;
  logic              clk;
  logic              rst_b;
  logic              instr_valid;
  bml_instr_t        instr;
  logic [ADDR_W-1:0] file_raddr;
  logic [DATA_W-1:0] file_rdata;
  bml_fwr_t          file_wr;
  logic [DATA_W-1:0] acc;
  logic              zero;
  logic              unknown_op;
  int                fails;
  int                checks_done;
  int                cycles;

  bml_exec DUT (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr), .acc(acc),
    .zero(zero), .unknown_op(unknown_op));
  bml_regfile_model regs (.clk(clk), .raddr(file_raddr), .rdata(file_rdata), .wr(file_wr));

  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task exec(input bml_instr_t i);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr       <= i;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task t_literal();
    chk("acc", acc, 16'h0000);
    chk("unknown_op", unknown_op, 16'h0000);
    exec(14'h305a);
    chk("acc", acc, 16'h005a);
    chk("zero", zero, 16'h0000);
    exec(14'h3000);
    chk("acc", acc, 16'h0000);
    chk("zero", zero, 16'h0000);
    $display("literal test done");
  endtask

  task t_store_incr();
    exec(14'h30ff);
    exec(14'h00ff);
    chk("file_wr", file_wr, {1'b1, 7'h7f, 8'hff});
    chk("zero", zero, 16'h0000);
    exec(14'h0aff);
    chk("file_wr", file_wr, {1'b1, 7'h7f, 8'h00});
    chk("zero", zero, 16'h0001);
    chk("acc", acc, 16'h00ff);
    exec(14'h0a7f);
    chk("acc", acc, 16'h0001);
    chk("zero", zero, 16'h0000);
    chk("wr_en", file_wr.en, 16'h0000);
    $display("store and increment test done");
  endtask

  task t_or_move();
    exec(14'h0090);
    exec(14'h3082);
    exec(14'h0410);
    chk("acc", acc, 16'h0083);
    exec(14'h0490);
    chk("file_wr", file_wr, {1'b1, 7'h10, 8'h83});
    exec(14'h3000);
    exec(14'h0400);
    chk("zero", zero, 16'h0001);
    exec(14'h00b0);
    chk("zero", zero, 16'h0001);
    exec(14'h3077);
    chk("zero", zero, 16'h0001);
    exec(14'h0890);
    chk("file_wr", file_wr, {1'b1, 7'h10, 8'h83});
    chk("zero", zero, 16'h0000);
    exec(14'h0810);
    chk("acc", acc, 16'h0083);
    chk("file_raddr", file_raddr, 16'h0010);
    $display("or and move test done");
  endtask

  task t_back_to_back();
    exec(14'h3000);
    exec(14'h00a0);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr       <= 14'h3044;
    @(posedge clk);
    instr       <= 14'h00a0;
    @(posedge clk);
    instr       <= 14'h08a0;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    // move reads the address written one cycle earlier
    chk("file_wr", file_wr, {1'b1, 7'h20, 8'h44});
    chk("zero", zero, 16'h0000);
    chk("acc", acc, 16'h0044);
    $display("back to back test done");
  endtask

  task t_idle();
    exec(14'h0000);
    chk("wr_en", file_wr.en, 16'h0000);
    chk("acc", acc, 16'h0044);
    chk("zero", zero, 16'h0000);
    exec(14'h3f00);
    chk("unknown_op", unknown_op, 16'h0001);
    chk("acc", acc, 16'h0044);
    $display("idle test done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      finish_test();
    end
  end

  initial
  begin
    rst_b       = 1'b0;
    instr_valid = 1'b0;
    instr       = 14'h0000;
    fails       = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_literal();
    t_store_incr();
    t_or_move();
    t_back_to_back();
    t_idle();
    finish_test();
  end
endmodule
`default_nettype wire
